// ### rpr_rpdo_receiver.sv
/*
  Receive process data object engine: four communication and mapping
  records, identifier match, sync/event apply, inhibit and deadline.
  Assumes frames arrive already checked by a CAN controller, a decoded
  SYNC pulse and the node's network state; all inputs synchronous.
*/
// Function
// [R1] Accept payloads of one to eight bytes
// [R2] Never acknowledge a received data object
// [R3] Process frames only in operational state
// [R4] Mapping changes only in pre-operational state
// [R5] At most four mapped objects per object
// [R6] Mapped lengths sum to at most 64 bits
// [R7] Four records, entry zero gives entry count
// [R8] Identifier bit 31 set disables the object
// [R9] Bit 29 selects extended identifier, 30 reserved
// [R10] Match bits 10-0, and 28-11 when extended
// [R11] Types 0-240 apply on next SYNC
// [R12] Types 254/255 apply data at once
// [R13] Inhibit in 100 us units, zero disables
// [R14] Refuse inhibit write while object valid
// [R15] Sub-index 4 aborts with 0609 0011h
// [R16] Event timer in 1 ms units, zero disables
// [R17] Monitoring starts at next reception, restarts
// [R18] Expired deadline raises timeout to application
// [R19] Sub-index 6 aborts with 0609 0011h
// [R20] Master sends SYNC periodically
// [R21] Both ends share the mapping list
// [R22] Abort frame: 0x580+node, 0x80, index, code
// [R23] Default identifiers 0x200..0x500 plus node
// [R24] Prescaler gives 100 us and 1 ms ticks
// [R25] Sync payload buffered, newest wins, atomic commit
`timescale 1ns/10ps
`default_nettype none
`include "rpr_defs.svh"

module rpr_rpdo_receiver import rpr_pkg::*; #(
  parameter int TICK_CYCLES = `RPR_TICK_CYCLES,
  parameter int NPDO        = 4
)(
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic [6:0]            nodeId,
  input  wire rpr_nmt_t              nmtState,
  input  wire logic                  rxValid,
  input  wire logic                  rxExt,
  input  wire logic [28:0]           rxId,
  input  wire logic [3:0]            rxDlc,
  input  wire logic [63:0]           rxData,
  input  wire logic                  syncEvt,
  input  wire logic                  odReq,
  input  wire logic                  odWr,
  input  wire logic [15:0]           odIndex,
  input  wire logic [7:0]            odSub,
  input  wire logic [31:0]           odWdata,
  output logic                       odDone,
  output logic                       odAbort,
  output logic [31:0]                odRdata,
  output logic                       abortValid,
  output logic [10:0]                abortId,
  output logic [63:0]                abortData,
  output logic [NPDO-1:0]            appStrobe,
  output logic [NPDO-1:0][63:0]      appData,
  output logic [NPDO-1:0]            appTimeout
);

  // Sums the bit lengths of the first n mapping entries
  function automatic logic [10:0] mapBits(input logic [3:0][31:0] ent,
                                          input logic [2:0] n);
    logic [10:0] sum;
    sum = 11'h000;
    for (int i = 0; i < 4; i++)
      if (3'(i) < n)
        sum = sum + {3'h0, ent[i][7:0]};
    return sum;
  endfunction : mapBits

  logic                       tick100;
  logic                       tick1ms;
  logic                       defLoad;
  logic [6:0]                 nodeLatch;
  logic [NPDO-1:0][31:0]      cobId;
  logic [NPDO-1:0][7:0]       txType;
  logic [NPDO-1:0][15:0]      inhibit;
  logic [NPDO-1:0][15:0]      evTimer;
  logic [NPDO-1:0][2:0]       mapCnt;
  logic [NPDO-1:0][3:0][31:0] mapEnt;
  logic [NPDO-1:0][15:0]      inhCnt;
  logic [NPDO-1:0][15:0]      evCnt;
  rpr_mon_t                   monState [NPDO];
  logic [NPDO-1:0]            pend;
  logic [NPDO-1:0][63:0]      pendData;
  logic [NPDO-1:0]            hit;
  logic [NPDO-1:0]            isSync;

  rpr_tick #(
    .TICK_CYCLES (TICK_CYCLES),
    .MS_DIV      (`RPR_MS_DIV)
  ) u_tick (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .tick100 (tick100),
    .tick1ms (tick1ms)
  ); // R24

  // Node number strap is caught in the first cycle after reset release
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      defLoad   <= 1'b1;
      nodeLatch <= 7'h00;
    end else begin
      defLoad   <= 1'b0;
      if (defLoad)
        nodeLatch <= nodeId;
    end
  end

  // Object access decode
  wire        isComm   = (odIndex[15:2] == 14'(`RPR_COMM_BASE >> 2));
  wire        isMap    = (odIndex[15:2] == 14'(`RPR_MAP_BASE >> 2));
  wire [1:0]  sel      = odIndex[1:0];
  wire        preOp    = (nmtState == RPR_PREOP);
  wire        entSub   = (odSub != `RPR_SUB_COUNT) && (odSub <= 8'h04);
  wire [1:0]  entIdx   = 2'(odSub - 8'h01);
  wire [7:0]  wrLen    = odWdata[7:0];
  wire        ttResv   = (odWdata[7:0] > `RPR_TT_SYNC_MAX) &&
                         (odWdata[7:0] < `RPR_TT_EVENT_MIN);

  // Candidate mapping with the written entry replaced, for length checks
  logic [3:0][31:0] candEnt;
  always_comb begin
    candEnt = mapEnt[sel];
    if (entSub)
      candEnt[entIdx] = odWdata;
  end
  wire [10:0] candBits = mapBits(candEnt, mapCnt[sel]);
  wire [10:0] cntBits  = mapBits(mapEnt[sel], odWdata[2:0]);

  // Abort code and read value of an access; zero code means success
  logic [31:0] code;
  logic [31:0] rdVal;
  always_comb begin
    code  = 32'h0000_0000;
    rdVal = 32'h0000_0000;
    if (isComm) begin
      case (odSub)
        `RPR_SUB_COUNT: begin // R7
          rdVal = `RPR_COMM_ENTRIES;
          if (odWr)
            code = `RPR_AB_READ_ONLY;
        end
        `RPR_SUB_IDENT: rdVal = cobId[sel];
        `RPR_SUB_TTYPE: begin
          rdVal = {24'h000000, txType[sel]};
          if (odWr && ttResv)
            code = `RPR_AB_BAD_VALUE; // R11
        end
        `RPR_SUB_INHIBIT: begin
          rdVal = {16'h0000, inhibit[sel]};
          if (odWr && !cobId[sel][`RPR_ID_INVALID])
            code = `RPR_AB_INCOMPAT; // R14
        end
        `RPR_SUB_EVTIMER: rdVal = {16'h0000, evTimer[sel]};
        default: code = `RPR_AB_NO_SUB; // R15 R19
      endcase
    end else if (isMap) begin
      if (odSub == `RPR_SUB_COUNT) begin
        rdVal = {29'h0, mapCnt[sel]};
        if (odWr && !preOp)
          code = `RPR_AB_BAD_STATE; // R4
        else if (odWr && (odWdata > 32'(`RPR_MAX_OBJECTS) ||
                          cntBits > `RPR_MAX_BITS))
          code = `RPR_AB_MAP_LEN; // R5 R6
      end else if (odSub <= `RPR_SUB_MAP_LAST) begin
        rdVal = entSub ? mapEnt[sel][entIdx] : 32'h0000_0000; // R21
        if (odWr && !preOp)
          code = `RPR_AB_BAD_STATE; // R4
        else if (odWr && !entSub && odWdata != 32'h0000_0000)
          code = `RPR_AB_MAP_LEN; // R5
        else if (odWr && entSub && (candBits > `RPR_MAX_BITS ||
                                    {3'h0, wrLen} > `RPR_MAX_BITS))
          code = `RPR_AB_MAP_LEN; // R6
      end else begin
        code = `RPR_AB_NO_SUB;
      end
    end else begin
      code = `RPR_AB_NO_OBJ;
    end
  end

  wire wrOk = odReq && odWr && (code == 32'h0000_0000);

  // Access answer and abort frame, one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      odDone     <= 1'b0;
      odAbort    <= 1'b0;
      odRdata    <= 32'h0000_0000;
      abortValid <= 1'b0;
      abortId    <= 11'h000;
      abortData  <= 64'h0;
    end else begin
      odDone     <= odReq;
      odAbort    <= odReq && (code != 32'h0000_0000);
      odRdata    <= (odReq && !odWr) ? rdVal : 32'h0000_0000;
      abortValid <= odReq && (code != 32'h0000_0000);
      abortId    <= `RPR_ABORT_ID + {4'h0, nodeLatch}; // R22
      abortData  <= {code, odSub, odIndex[15:8], odIndex[7:0],
                     `RPR_ABORT_CMD}; // R22
    end
  end

  genvar p;
  generate
    for (p = 0; p < NPDO; p++) begin : g_pdo
      wire wrThis  = wrOk && (sel == 2'(p));
      wire idMatch = (rxExt == cobId[p][`RPR_ID_EXTENDED]) && // R9
                     (rxId[10:0] == cobId[p][10:0]) && // R10
                     (!rxExt || rxId[28:11] == cobId[p][28:11]);
      wire dlcOk   = (rxDlc != 4'h0) && (rxDlc <= 4'h8); // R1

      // Frames are only consumed; nothing is ever sent back for them
      assign hit[p]    = rxValid && (nmtState == RPR_OPER) && // R3
                         !cobId[p][`RPR_ID_INVALID] && // R8
                         dlcOk && idMatch && (inhCnt[p] == 16'h0000); // R2
      assign isSync[p] = (txType[p] <= `RPR_TT_SYNC_MAX); // R11

      // Communication record; identifier defaults loaded once node number is known, the other defaults at reset
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          cobId[p]   <= 32'h0000_0000;
          txType[p]  <= `RPR_DEF_TTYPE;
          inhibit[p] <= `RPR_DEF_INHIBIT;
          evTimer[p] <= `RPR_DEF_EVTIMER;
        end else if (defLoad) begin
          cobId[p]   <= {21'h0, `RPR_ID_BASE_FIRST + 11'(p) *
                         `RPR_ID_BASE_STEP + {4'h0, nodeId}}; // R23
        end else if (wrThis && isComm) begin
          case (odSub)
            `RPR_SUB_IDENT:   cobId[p]   <= odWdata;
            `RPR_SUB_TTYPE:   txType[p]  <= odWdata[7:0];
            `RPR_SUB_INHIBIT: inhibit[p] <= odWdata[15:0]; // R13
            `RPR_SUB_EVTIMER: evTimer[p] <= odWdata[15:0]; // R16
            default:          cobId[p]   <= cobId[p];
          endcase
        end
      end

      // Mapping record with its default contents
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          mapCnt[p] <= (p == 0) ? 3'h3 : (p < 3) ? 3'h2 : 3'h0;
          mapEnt[p] <= (p == 0) ? {32'h0, `RPR_MAP_DOUT, `RPR_MAP_MODE,
                                   `RPR_MAP_CTRL} :
                       (p == 1) ? {64'h0, `RPR_MAP_TPOS, `RPR_MAP_CTRL} :
                       (p == 2) ? {64'h0, `RPR_MAP_TVEL, `RPR_MAP_CTRL} :
                                  128'h0;
        end else if (wrThis && isMap && odSub == `RPR_SUB_COUNT) begin
          mapCnt[p] <= odWdata[2:0]; // R5
        end else if (wrThis && isMap && entSub) begin
          mapEnt[p][entIdx] <= odWdata; // R4
        end
      end

      // Inhibit window after each accepted frame
      always_ff @(posedge sys_clk) begin
        if (!rstn)
          inhCnt[p] <= 16'h0000;
        else if (hit[p])
          inhCnt[p] <= inhibit[p]; // R13
        else if (tick100 && inhCnt[p] != 16'h0000)
          inhCnt[p] <= inhCnt[p] - 16'h0001;
      end

      // Sync buffer; a frame in the SYNC cycle stays pending (set wins)
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          pend[p]     <= 1'b0;
          pendData[p] <= 64'h0;
        end else if (hit[p] && isSync[p]) begin
          pend[p]     <= 1'b1;
          pendData[p] <= rxData; // R25
        end else if (syncEvt || nmtState != RPR_OPER) begin
          pend[p]     <= 1'b0; // R20
        end
      end

      // Application side: sync commit or immediate event apply
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          appStrobe[p] <= 1'b0;
          appData[p]   <= 64'h0;
        end else if (hit[p] && !isSync[p]) begin
          appStrobe[p] <= 1'b1;
          appData[p]   <= rxData; // R12
        end else if (syncEvt && pend[p] && nmtState == RPR_OPER) begin
          appStrobe[p] <= 1'b1;
          appData[p]   <= pendData[p]; // R11 R25
        end else begin
          appStrobe[p] <= 1'b0;
        end
      end

      // Deadline monitor: armed by reception, disarmed by an event timer write
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          monState[p]   <= RPR_MON_OFF;
          evCnt[p]      <= 16'h0000;
          appTimeout[p] <= 1'b0;
        end else begin
          appTimeout[p] <= 1'b0;
          case (monState[p])
            RPR_MON_OFF: begin
              if (hit[p] && evTimer[p] != 16'h0000) begin
                monState[p] <= RPR_MON_ARMED; // R17
                evCnt[p]    <= evTimer[p];
              end
            end
            RPR_MON_ARMED: begin
              if (wrThis && isComm && odSub == `RPR_SUB_EVTIMER) begin
                monState[p] <= RPR_MON_OFF; // R17
              end else if (hit[p]) begin
                evCnt[p]    <= evTimer[p]; // R17
                monState[p] <= (evTimer[p] == 16'h0000) ? RPR_MON_OFF :
                               RPR_MON_ARMED; // R16
              end else if (tick1ms) begin
                if (evCnt[p] == 16'h0001) begin
                  monState[p]   <= RPR_MON_OFF;
                  appTimeout[p] <= 1'b1; // R18
                end else begin
                  evCnt[p] <= evCnt[p] - 16'h0001;
                end
              end
            end
            default: monState[p] <= RPR_MON_OFF;
          endcase
        end
      end
    end
  endgenerate

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  abort_frame_a: assert property (abortValid |-> $past(odReq) && // R22
    abortData[7:0] == `RPR_ABORT_CMD && abortId == `RPR_ABORT_ID +
    {4'h0, nodeLatch}) else $error("abort frame malformed");
  sub4_abort_a: assert property (odReq && isComm && odSub == 8'h04 |=> // R15
    odAbort && abortData[63:32] == `RPR_AB_NO_SUB)
    else $error("sub-index 4 not aborted");
  sub6_abort_a: assert property (odReq && isComm && odSub == 8'h06 |=> // R19
    odAbort && abortData[63:32] == `RPR_AB_NO_SUB)
    else $error("sub-index 6 not aborted");
  oper_only_a: assert property (nmtState != RPR_OPER |=> !(|appStrobe)) // R3
    else $error("frame taken outside operational");
  invalid_off_a: assert property (rxValid && !syncEvt && // R8
    cobId[2][31] && !isSync[2] |=> !appStrobe[2])
    else $error("invalid object consumed");
  event_apply_a: assert property (hit[0] && !isSync[0] |=> // R12
    appStrobe[0] && appData[0] == $past(rxData))
    else $error("event data not applied");
  sync_apply_a: assert property (appStrobe[1] && isSync[1] |-> // R11
    $past(syncEvt)) else $error("sync data applied without SYNC");
  inhibit_ro_a: assert property (odReq && odWr && isComm && // R14
    odSub == 8'h03 && !cobId[sel][31] |=> odAbort && $stable(inhibit))
    else $error("inhibit written while valid");
  map_limit_a: assert property (mapCnt[0] <= 3'h4 && // R5
    mapBits(mapEnt[0], mapCnt[0]) <= 11'h040)
    else $error("mapping over limit");
  timeout_src_a: assert property (appTimeout[3] |-> // R18
    $past(monState[3] == RPR_MON_ARMED && tick1ms))
    else $error("timeout without armed monitor");
  dlc_range_a: assert property (rxValid && !syncEvt && // R1
    (rxDlc == 4'h0 || rxDlc > 4'h8) |=> !(|appStrobe))
    else $error("bad length accepted");

endmodule : rpr_rpdo_receiver
`default_nettype wire

// ### rpr_defs.svh
/*
  Constants of the receive process data object block: object indices,
  sub-indices, defaults, abort codes and time bases.
  Assumes inclusion by the receiver and prescaler design modules.
*/
`ifndef RPR_DEFS_SVH
`define RPR_DEFS_SVH

// Time bases
`define RPR_CLK_MHZ       125
`define RPR_INHIBIT_US    100
`define RPR_EVENT_US      1000
`define RPR_TICK_CYCLES   (`RPR_INHIBIT_US * `RPR_CLK_MHZ)
`define RPR_MS_DIV        (`RPR_EVENT_US / `RPR_INHIBIT_US)

// Object dictionary layout
`define RPR_COMM_BASE     16'h1400
`define RPR_MAP_BASE      16'h1600
`define RPR_SUB_COUNT     8'h00
`define RPR_SUB_IDENT     8'h01
`define RPR_SUB_TTYPE     8'h02
`define RPR_SUB_INHIBIT   8'h03
`define RPR_SUB_EVTIMER   8'h05
`define RPR_SUB_MAP_LAST  8'h08
`define RPR_COMM_ENTRIES  32'h0000_0005
`define RPR_MAX_OBJECTS   3'h4
`define RPR_MAX_BITS      11'h040

// Identifier entry fields
`define RPR_ID_INVALID    31
`define RPR_ID_EXTENDED   29

// Transmission types
`define RPR_TT_SYNC_MAX   8'hf0
`define RPR_TT_EVENT_MIN  8'hfe

// Defaults
`define RPR_DEF_TTYPE     8'hfe
`define RPR_DEF_INHIBIT   16'h0005
`define RPR_DEF_EVTIMER   16'h0000
`define RPR_ID_BASE_STEP  11'h100
`define RPR_ID_BASE_FIRST 11'h200
`define RPR_MAP_CTRL      32'h6040_0010
`define RPR_MAP_MODE      32'h6060_0008
`define RPR_MAP_DOUT      32'h60fe_0120
`define RPR_MAP_TPOS      32'h607a_0020
`define RPR_MAP_TVEL      32'h60ff_0020

// Abort frame
`define RPR_ABORT_ID      11'h580
`define RPR_ABORT_CMD     8'h80
`define RPR_AB_NO_SUB     32'h0609_0011
`define RPR_AB_NO_OBJ     32'h0602_0000
`define RPR_AB_READ_ONLY  32'h0601_0002
`define RPR_AB_BAD_VALUE  32'h0609_0030
`define RPR_AB_INCOMPAT   32'h0604_0043
`define RPR_AB_MAP_LEN    32'h0604_0042
`define RPR_AB_BAD_STATE  32'h0800_0022

`endif

// ### rpr_pkg.sv
/*
  Types of the receive process data object block.
  Assumes nothing beyond the constant header.
*/
package rpr_pkg;

  // Network states as presented by the node's state machine
  typedef enum logic [1:0] {
    RPR_INIT    = 2'b11,
    RPR_PREOP   = 2'b10,
    RPR_OPER    = 2'b01,
    RPR_STOPPED = 2'b00
  } rpr_nmt_t;

  // Deadline monitor of one receive object
  typedef enum logic {
    RPR_MON_OFF   = 1'b0,
    RPR_MON_ARMED = 1'b1
  } rpr_mon_t;

endpackage : rpr_pkg

// ### rpr_tick.sv
/*
  Time base prescaler: one-cycle 100 us and 1 ms tick enables.
  Assumes a free-running system clock at the documented rate.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rpr_defs.svh"

module rpr_tick #(
  parameter int TICK_CYCLES = `RPR_TICK_CYCLES,
  parameter int MS_DIV      = `RPR_MS_DIV
)(
  input  wire logic sys_clk,
  input  wire logic rstn,
  output logic      tick100,
  output logic      tick1ms
);

  logic [15:0] preCnt;
  logic [3:0]  msCnt;
  wire         preWrap = (preCnt == 16'(TICK_CYCLES - 1));
  wire         msWrap  = (msCnt == 4'(MS_DIV - 1));

  // Prescaler; the millisecond tick is a tenth of the short ticks
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      preCnt  <= 16'h0000;
      msCnt   <= 4'h0;
      tick100 <= 1'b0;
      tick1ms <= 1'b0;
    end else begin
      preCnt  <= preWrap ? 16'h0000 : preCnt + 16'h0001;
      tick100 <= preWrap;
      tick1ms <= preWrap && msWrap;
      if (preWrap)
        msCnt <= msWrap ? 4'h0 : msCnt + 4'h1;
    end
  end

endmodule : rpr_tick
`default_nettype wire

// ### rpr_master_model.sv
/*
  Behavioural network master: sends receive data frames and SYNC pulses.
  Assumes its tasks are called from a process that follows sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module rpr_master_model (
  input  wire logic   sys_clk,
  output logic        rxValid,
  output logic        rxExt,
  output logic [28:0] rxId,
  output logic [3:0]  rxDlc,
  output logic [63:0] rxData,
  output logic        syncEvt
);
  // Quiet bus at start
  initial begin
    rxValid = 1'b0;
    rxExt   = 1'b0;
    rxId    = 29'h0;
    rxDlc   = 4'h0;
    rxData  = 64'h0;
    syncEvt = 1'b0;
  end

  // One frame for one cycle; fields flip afterwards so stale data shows
  task send_frame(input logic ext, input logic [28:0] id,
                  input logic [3:0] dlc, input logic [63:0] d);
    @(posedge sys_clk);
    rxValid <= 1'b1;
    rxExt   <= ext;
    rxId    <= id;
    rxDlc   <= dlc;
    rxData  <= d;
    @(posedge sys_clk);
    rxValid <= 1'b0;
    rxExt   <= ~ext;
    rxId    <= ~id;
    rxDlc   <= ~dlc;
    rxData  <= ~d;
  endtask : send_frame

  // Periodic on a real network; here the bench picks the moment
  task send_sync;
    @(posedge sys_clk);
    syncEvt <= 1'b1;
    @(posedge sys_clk);
    syncEvt <= 1'b0;
  endtask : send_sync
endmodule : rpr_master_model
`default_nettype wire

// ### rpr_testbench.sv
/*
  Self-checking bench of the receive data object engine.
  Assumes the package, the design and the master model compile first.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench import rpr_pkg::*;;
  logic             sys_clk  = 1'b0;
  logic             rstn     = 1'b0;
  logic [6:0]       nodeId   = 7'h05;
  rpr_nmt_t         nmtState = RPR_PREOP;
  logic             odReq    = 1'b0;
  logic             odWr     = 1'b0;
  logic [15:0]      odIndex  = 16'h0;
  logic [7:0]       odSub    = 8'h0;
  logic [31:0]      odWdata  = 32'h0;
  wire logic        rxValid, rxExt, syncEvt;
  wire logic [28:0] rxId;
  wire logic [3:0]  rxDlc;
  wire logic [63:0] rxData;
  logic             odDone, odAbort, abortValid;
  logic [31:0]      odRdata;
  logic [10:0]      abortId;
  logic [63:0]      abortData;
  logic [3:0]       appStrobe, appTimeout;
  logic [3:0][63:0] appData;
  int               n_fail = 0, compares = 0, cyc = 0, avCnt = 0;
  int               sc[4] = '{0, 0, 0, 0}, tc[4] = '{0, 0, 0, 0};
  logic [2:0]       rFlags;
  logic [31:0]      rRd;
  logic [63:0]      rAb;

  // Short tick so 1 ms is 100 cycles and runs stay brief
  rpr_rpdo_receiver #(.TICK_CYCLES(10), .NPDO(4)) uut (
    .sys_clk, .rstn, .nodeId, .nmtState, .rxValid, .rxExt, .rxId, .rxDlc,
    .rxData, .syncEvt, .odReq, .odWr, .odIndex, .odSub, .odWdata, .odDone,
    .odAbort, .odRdata, .abortValid, .abortId, .abortData, .appStrobe,
    .appData, .appTimeout);
  rpr_master_model master (.sys_clk, .rxValid, .rxExt, .rxId, .rxDlc,
    .rxData, .syncEvt);

  always #4 sys_clk = ~sys_clk;

  // Pulse counters and hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (abortValid === 1'b1) avCnt <= avCnt + 1;
    for (int p = 0; p < 4; p++) begin
      if (appStrobe[p] === 1'b1) sc[p] <= sc[p] + 1;
      if (appTimeout[p] === 1'b1) tc[p] <= tc[p] + 1;
    end
    if (cyc == 20000) begin
      n_fail++;
      $display("Error at %0t ns: run did not finish", $time);
      finish_test;
    end
  end

  task finish_test;
    $display("Counts: compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [28:0] sid(input logic [10:0] b);
    return {18'h0, b + {4'h0, nodeId}};
  endfunction : sid

  // One access; the answer is sampled just after the taking edge
  task od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
          input logic [31:0] wd);
    @(posedge sys_clk);
    odReq   <= 1'b1;
    odWr    <= wr;
    odIndex <= idx;
    odSub   <= sub;
    odWdata <= wd;
    @(posedge sys_clk);
    odReq   <= 1'b0;
    #1;
    rFlags = {odDone, odAbort, abortValid};
    rRd    = odRdata;
    rAb    = abortData;
  endtask : od

  // Accepted access; on a read wd is the expected value
  task ok(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
          input logic [31:0] wd);
    od(wr, idx, sub, wr ? wd : 32'h0);
    chk({61'h0, rFlags}, 64'h4);
    if (!wr) chk({32'h0, rRd}, {32'h0, wd});
  endtask : ok

  task ab(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
          input logic [31:0] wd, input logic [31:0] code);
    od(wr, idx, sub, wd);
    chk({61'h0, rFlags}, 64'h7);
    chk(rAb, {code, sub, idx, 8'h80});
  endtask : ab

  task t_defaults;
    chk({53'h0, abortId}, {53'h0, 11'h580 + {4'h0, nodeId}});
    ok(0, 16'h1400, 8'h00, 32'h5);
    for (int p = 0; p < 4; p++)
      ok(0, 16'h1400 + 16'(p), 8'h01, {3'h0, sid(11'h200 + 11'(p * 256))});
    ok(0, 16'h1403, 8'h03, 32'h5);
    ok(0, 16'h1400, 8'h05, 32'h0);
    ok(0, 16'h1600, 8'h03, 32'h60fe_0120);
    $display("t_defaults done");
  endtask : t_defaults

  task t_map;
    ok(1, 16'h1603, 8'h01, 32'h6000_0040);
    ok(1, 16'h1603, 8'h02, 32'h6000_0008);
    ok(1, 16'h1603, 8'h00, 32'h1);
    ab(1, 16'h1603, 8'h00, 32'h2, 32'h0604_0042);
    ab(1, 16'h1603, 8'h00, 32'h5, 32'h0604_0042);
    ok(0, 16'h1603, 8'h00, 32'h1);
    @(posedge sys_clk);
    nmtState <= RPR_OPER;
    ab(1, 16'h1603, 8'h00, 32'h0, 32'h0800_0022);
    $display("t_map done");
  endtask : t_map

  task t_aborts;
    ab(0, 16'h1400, 8'h04, 32'h0, 32'h0609_0011);
    ab(1, 16'h1402, 8'h04, 32'h1, 32'h0609_0011);
    ab(0, 16'h1401, 8'h06, 32'h0, 32'h0609_0011);
    ab(1, 16'h1403, 8'h06, 32'h1, 32'h0609_0011);
    ab(1, 16'h1400, 8'h00, 32'h6, 32'h0601_0002);
    ab(1, 16'h1400, 8'h02, 32'hf1, 32'h0609_0030);
    ab(1, 16'h1400, 8'h02, 32'hfd, 32'h0609_0030);
    ab(1, 16'h1400, 8'h03, 32'h0, 32'h0604_0043);
    ab(0, 16'h1404, 8'h01, 32'h0, 32'h0602_0000);
    ok(0, 16'h1400, 8'h02, 32'hfe);
    ok(1, 16'h1402, 8'h02, 32'hf0);
    ok(1, 16'h1402, 8'h02, 32'hff);
    ok(0, 16'h1402, 8'h02, 32'hff);
    $display("t_aborts done");
  endtask : t_aborts

  task t_event;
    int s;
    int a;
    s = sc[0];
    a = avCnt;
    master.send_frame(1'b0, sid(11'h200), 4'h2, 64'ha55a);
    #1;
    chk({63'h0, appStrobe[0]}, 64'h1);
    chk(appData[0], 64'ha55a);
    master.send_frame(1'b0, sid(11'h200), 4'h1, 64'h11);
    repeat (60) @(posedge sys_clk);
    master.send_frame(1'b0, sid(11'h200), 4'h0, 64'h0);
    master.send_frame(1'b0, sid(11'h200), 4'h9, 64'h22);
    repeat (3) @(posedge sys_clk);
    chk(64'(sc[0] - s), 64'h1);
    master.send_frame(1'b0, sid(11'h200), 4'h8, 64'h0123_4567_89ab_cdef);
    #1;
    chk(appData[0], 64'h0123_4567_89ab_cdef);
    @(posedge sys_clk);
    nmtState <= RPR_STOPPED;
    repeat (60) @(posedge sys_clk);
    master.send_frame(1'b0, sid(11'h200), 4'h1, 64'h33);
    repeat (3) @(posedge sys_clk);
    chk(64'(sc[0] - s), 64'h2);
    chk(64'(avCnt - a), 64'h0);
    nmtState <= RPR_OPER;
    $display("t_event done");
  endtask : t_event

  task t_sync;
    int s;
    ok(1, 16'h1401, 8'h02, 32'h0);
    s = sc[1];
    master.send_frame(1'b0, sid(11'h300), 4'h4, 64'h1111_2222);
    repeat (60) @(posedge sys_clk);
    master.send_frame(1'b0, sid(11'h300), 4'h4, 64'h3333_4444);
    repeat (3) @(posedge sys_clk);
    chk(64'(sc[1] - s), 64'h0);
    master.send_sync;
    #1;
    chk({63'h0, appStrobe[1]}, 64'h1);
    chk(appData[1], 64'h3333_4444);
    $display("t_sync done");
  endtask : t_sync

  task t_ident;
    int s;
    s = sc[2];
    ok(1, 16'h1402, 8'h01, {3'h4, sid(11'h400)});
    master.send_frame(1'b0, sid(11'h400), 4'h1, 64'h1);
    ok(1, 16'h1402, 8'h03, 32'h0);
    ok(1, 16'h1402, 8'h01, 32'h2012_3405);
    master.send_frame(1'b0, 29'h405, 4'h1, 64'h2);
    master.send_frame(1'b1, 29'h0012_3c05, 4'h1, 64'h3);
    master.send_frame(1'b1, 29'h0012_3405, 4'h3, 64'habcdef);
    #1;
    chk(appData[2], 64'habcdef);
    repeat (3) @(posedge sys_clk);
    chk(64'(sc[2] - s), 64'h1);
    $display("t_ident done");
  endtask : t_ident

  // Three ms deadline: expiry lands 200 to 300 cycles after a frame
  task t_deadline;
    ok(1, 16'h1403, 8'h05, 32'h3);
    repeat (300) @(posedge sys_clk);
    chk(64'(tc[3]), 64'h0);
    master.send_frame(1'b0, sid(11'h500), 4'h2, 64'h77);
    repeat (150) @(posedge sys_clk);
    chk(64'(tc[3]), 64'h0);
    master.send_frame(1'b0, sid(11'h500), 4'h2, 64'h78);
    repeat (150) @(posedge sys_clk);
    chk(64'(tc[3]), 64'h0);
    repeat (260) @(posedge sys_clk);
    chk(64'(tc[3]), 64'h1);
    $display("t_deadline done");
  endtask : t_deadline

  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_defaults;
    t_map;
    t_aborts;
    t_event;
    t_sync;
    t_ident;
    t_deadline;
    finish_test;
  end
endmodule : testbench
`default_nettype wire
